// [hw/hyp_trap_deleg.v]
// hypervisor trap delegation and guest interrupt pending/enable logic
`timescale 1ns/10ps
`default_nettype none
`include "hyp_trap_defines.vh"

module hyp_trap_deleg
#(
    parameter HOST_WIDTH_32 = 0,
    parameter INSTRUCTION_ALIGNMENT = 32
)
(
    input wire clock,
    input wire arst_n,
    input wire csr_read,
    input wire csr_write,
    input wire [2:0] csr_select,
    input wire [63:0] csr_wdata,
    output reg [63:0] csr_rdata_q,
    output reg csr_missing_q,
    input wire exc_valid,
    input wire [5:0] exc_cause,
    input wire exc_routed_to_host,
    input wire guest_mode_before,
    output reg exc_to_guest_q,
    input wire at_host_level,
    input wire below_host_level,
    input wire sup_global_enable,
    input wire [63:0] sup_pending_enabled,
    input wire [63:0] host_routed,
    input wire [63:0] guest_ext_pending_vec,
    input wire [63:0] guest_ext_enable_vec,
    input wire [5:0] guest_external_source_select,
    input wire platform_guest_external,
    input wire platform_guest_timer,
    output reg host_irq_q,
    output reg [5:0] host_irq_cause_q,
    output reg guest_irq_q,
    output reg [5:0] guest_irq_cause_q,
    output reg host_guest_external_pending_q
);

    // ************************************************************
    // platform pin synchronisers
    // ************************************************************
    reg plat_ext_meta_q;
    reg plat_ext_q;
    reg plat_tim_meta_q;
    reg plat_tim_q;

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            plat_ext_meta_q <= 1'b0;
            plat_ext_q <= 1'b0;
            plat_tim_meta_q <= 1'b0;
            plat_tim_q <= 1'b0;
        end
        else
        begin
            plat_ext_meta_q <= platform_guest_external;
            plat_ext_q <= plat_ext_meta_q;
            plat_tim_meta_q <= platform_guest_timer;
            plat_tim_q <= plat_tim_meta_q;
        end
    end

    // ************************************************************
    // storage and write masks
    // ************************************************************
    reg [63:0] exc_deleg_q;
    reg [63:0] irq_deleg_q;
    reg [63:0] virt_inject_q;
    reg [63:0] guest_enable_q;

    wire [63:0] exc_wmask;
    wire upper_exists;

    // bit 0 writable only with 32-bit alignment, others fixed
    assign exc_wmask = `EXC_DELEG_WMASK
        | ((INSTRUCTION_ALIGNMENT == `ALIGN_32) ? `EXC_MISALIGN_BIT : 64'h0000000000000000);
    assign upper_exists = (HOST_WIDTH_32 != 0);

    // low-word write in 32-bit width keeps the upper half
    wire [63:0] exc_low_data;
    wire [63:0] exc_up_data;
    assign exc_low_data = upper_exists ? {exc_deleg_q[63:32], csr_wdata[31:0]} : csr_wdata;
    assign exc_up_data = {csr_wdata[31:0], exc_deleg_q[31:0]};

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            exc_deleg_q <= 64'h0000000000000000;
            irq_deleg_q <= 64'h0000000000000000;
            virt_inject_q <= 64'h0000000000000000;
            guest_enable_q <= 64'h0000000000000000;
        end
        else if (csr_write)
        begin
            if (csr_select == `SEL_EXC_DELEG)
            begin
                exc_deleg_q <= exc_low_data & exc_wmask;
            end
            else if (csr_select == `SEL_EXC_DELEG_UPPER && upper_exists)
            begin
                exc_deleg_q <= exc_up_data & exc_wmask;
            end
            else if (csr_select == `SEL_IRQ_DELEG)
            begin
                irq_deleg_q <= csr_wdata & `IRQ_DELEG_WMASK;
            end
            else if (csr_select == `SEL_VIRT_INJECT)
            begin
                virt_inject_q <= csr_wdata & `VIRT_INJECT_WMASK;
            end
            else if (csr_select == `SEL_GUEST_PENDING)
            begin
                // only the software bit is writable; it shares injection storage
                virt_inject_q <= (virt_inject_q & ~`GUEST_PENDING_WMASK)
                    | (csr_wdata & `GUEST_PENDING_WMASK);
            end
            else if (csr_select == `SEL_GUEST_ENABLE)
            begin
                guest_enable_q <= csr_wdata & `GUEST_ENABLE_WMASK;
            end
        end
    end

    // ************************************************************
    // guest pending vector
    // ************************************************************
    wire host_guest_ext_pend;
    wire selected_source;
    wire guest_ext_pend;
    wire guest_tim_pend;
    wire guest_sw_pend;
    reg [63:0] guest_pending;

    assign host_guest_ext_pend = |(guest_ext_pending_vec & guest_ext_enable_vec);
    assign selected_source = (guest_external_source_select != 6'h00)
        & guest_ext_pending_vec[guest_external_source_select];
    assign guest_ext_pend = virt_inject_q[`BIT_GUEST_EXTERNAL] | selected_source | plat_ext_q;
    assign guest_tim_pend = virt_inject_q[`BIT_GUEST_TIMER] | plat_tim_q;
    assign guest_sw_pend = virt_inject_q[`BIT_GUEST_SOFTWARE];

    always @*
    begin
        guest_pending = 64'h0000000000000000;
        guest_pending[`BIT_HOST_GUEST_EXT] = host_guest_ext_pend;
        guest_pending[`BIT_GUEST_EXTERNAL] = guest_ext_pend;
        guest_pending[`BIT_GUEST_TIMER] = guest_tim_pend;
        guest_pending[`BIT_GUEST_SOFTWARE] = guest_sw_pend;
    end

    // ************************************************************
    // read port
    // ************************************************************
    reg [63:0] rd_value;
    reg rd_missing;

    always @*
    begin
        rd_value = 64'h0000000000000000;
        rd_missing = 1'b0;
        if (csr_select == `SEL_EXC_DELEG)
        begin
            rd_value = upper_exists ? {32'h00000000, exc_deleg_q[31:0]} : exc_deleg_q;
        end
        else if (csr_select == `SEL_EXC_DELEG_UPPER)
        begin
            rd_value = {32'h00000000, exc_deleg_q[63:32]};
            rd_missing = !upper_exists;
        end
        else if (csr_select == `SEL_IRQ_DELEG)
        begin
            rd_value = irq_deleg_q;
        end
        else if (csr_select == `SEL_VIRT_INJECT)
        begin
            rd_value = virt_inject_q;
        end
        else if (csr_select == `SEL_GUEST_PENDING)
        begin
            rd_value = guest_pending;
        end
        else if (csr_select == `SEL_GUEST_ENABLE)
        begin
            rd_value = guest_enable_q;
        end
        else
        begin
            rd_missing = 1'b1;
        end
    end

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            csr_rdata_q <= 64'h0000000000000000;
            csr_missing_q <= 1'b0;
        end
        else
        begin
            if (csr_read)
            begin
                csr_rdata_q <= rd_value;
            end
            csr_missing_q <= (csr_read | csr_write) & rd_missing;
        end
    end

    // ************************************************************
    // trap routing decisions
    // ************************************************************
    wire [63:0] guest_active;
    wire [63:0] host_cand;
    wire [63:0] guest_cand;
    wire host_enabled;
    reg host_take;
    reg [5:0] host_cause;
    reg guest_take;
    reg [5:0] guest_cause;

    assign guest_active = guest_pending & guest_enable_q;
    assign host_enabled = (at_host_level & sup_global_enable) | below_host_level;
    assign host_cand = (sup_pending_enabled | guest_active) & host_routed & ~irq_deleg_q;
    assign guest_cand = guest_active & host_routed & irq_deleg_q;

    always @*
    begin
        host_take = host_enabled;
        host_cause = 6'h00;
        if (host_cand[`BIT_SUP_EXTERNAL])
        begin
            host_cause = `CAUSE_SUP_EXTERNAL;
        end
        else if (host_cand[`BIT_SUP_SOFTWARE])
        begin
            host_cause = `CAUSE_SUP_SOFTWARE;
        end
        else if (host_cand[`BIT_SUP_TIMER])
        begin
            host_cause = `CAUSE_SUP_TIMER;
        end
        else if (host_cand[`BIT_HOST_GUEST_EXT])
        begin
            host_cause = `CAUSE_HOST_GUEST_EXT;
        end
        else if (host_cand[`BIT_GUEST_EXTERNAL])
        begin
            host_cause = `CAUSE_GUEST_EXTERNAL;
        end
        else if (host_cand[`BIT_GUEST_SOFTWARE])
        begin
            host_cause = `CAUSE_GUEST_SOFTWARE;
        end
        else if (host_cand[`BIT_GUEST_TIMER])
        begin
            host_cause = `CAUSE_GUEST_TIMER;
        end
        else
        begin
            host_take = 1'b0;
        end
    end

    // delegated guest causes are translated to supervisor codes
    always @*
    begin
        guest_take = 1'b1;
        guest_cause = 6'h00; // causes 16 and up are never delegated here
        if (guest_cand[`BIT_GUEST_EXTERNAL])
        begin
            guest_cause = `CAUSE_SUP_EXTERNAL;
        end
        else if (guest_cand[`BIT_GUEST_SOFTWARE])
        begin
            guest_cause = `CAUSE_SUP_SOFTWARE;
        end
        else if (guest_cand[`BIT_GUEST_TIMER])
        begin
            guest_cause = `CAUSE_SUP_TIMER;
        end
        else
        begin
            guest_take = 1'b0;
        end
    end

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            exc_to_guest_q <= 1'b0;
            host_irq_q <= 1'b0;
            host_irq_cause_q <= 6'h00;
            guest_irq_q <= 1'b0;
            guest_irq_cause_q <= 6'h00;
            host_guest_external_pending_q <= 1'b0;
        end
        else
        begin
            exc_to_guest_q <= exc_valid & exc_routed_to_host & guest_mode_before
                & exc_deleg_q[exc_cause];
            host_irq_q <= host_take;
            host_irq_cause_q <= host_cause;
            guest_irq_q <= guest_take;
            guest_irq_cause_q <= guest_cause;
            host_guest_external_pending_q <= host_guest_ext_pend;
        end
    end

endmodule
`default_nettype wire

// [common/hyp_trap_defines.vh]
// constants for the hypervisor trap delegation and guest interrupt block
// How it works
// - delegated-to-host exception goes to guest if guest flag set and delegation bit set
// - every exception delegation bit is writable or reads zero
// - exception delegation bit 0 writable when instruction alignment is 32
// - exception delegation bits 1-8, 12, 13, 15, 18, 19 writable
// - exception delegation bits 9-11 and 20-23 always read zero
// - upper alias register holds bits 63:32, only when host width is 32
// - host-routed interrupt goes on to guest when its delegation bit is set
// - interrupt delegation bits 10, 6, 2 writable; 12, 9, 5, 1 read zero
// - guest causes 10, 6, 2 are presented as 9, 5, 1 to the guest
// - platform causes 16 and up may be translated; not done here
// - injection register bits 10, 6, 2 writable, all others read zero
// - injected bits assert guest external, timer, software interrupts
// - supervisor-enable bits read zero in guest pending and enable registers
// - host trap needs host enable or lower level, pending and enabled, not delegated
// - writing 0 to a writable guest pending bit clears it
// - read-only guest pending bits 10 and 6 are cleared through the injection register; bit 12 is not
// - guest enable bit writable only where its interrupt can pend
// - host guest-external pending is OR of guest pending AND guest enable vectors
// - guest external pending is injected OR selected source OR platform signal
// - guest timer pending is injected timer OR platform guest timer
// - guest software pending aliases the injected software bit
// - enable positions are 12, 10, 6 and 2
// - host priority: sup ext, sup sw, sup timer, host guest-ext, guest ext, sw, timer
// - source selector zero selects no guest external source
// - guest external enable vector does not gate the selected source
`ifndef HYP_TRAP_DEFINES_VH
`define HYP_TRAP_DEFINES_VH

// register selector codes on the access port
`define SEL_EXC_DELEG 3'h0
`define SEL_EXC_DELEG_UPPER 3'h1
`define SEL_IRQ_DELEG 3'h2
`define SEL_VIRT_INJECT 3'h3
`define SEL_GUEST_PENDING 3'h4
`define SEL_GUEST_ENABLE 3'h5

// writable bit masks
`define EXC_DELEG_WMASK 64'h00000000000CB1FE
`define EXC_MISALIGN_BIT 64'h0000000000000001
`define IRQ_DELEG_WMASK 64'h0000000000000444
`define VIRT_INJECT_WMASK 64'h0000000000000444
`define GUEST_PENDING_WMASK 64'h0000000000000004
`define GUEST_ENABLE_WMASK 64'h0000000000001444

// interrupt bit positions
`define BIT_SUP_SOFTWARE 1
`define BIT_GUEST_SOFTWARE 2
`define BIT_SUP_TIMER 5
`define BIT_GUEST_TIMER 6
`define BIT_SUP_EXTERNAL 9
`define BIT_GUEST_EXTERNAL 10
`define BIT_HOST_GUEST_EXT 12

// cause codes
`define CAUSE_SUP_SOFTWARE 6'h01
`define CAUSE_GUEST_SOFTWARE 6'h02
`define CAUSE_SUP_TIMER 6'h05
`define CAUSE_GUEST_TIMER 6'h06
`define CAUSE_SUP_EXTERNAL 6'h09
`define CAUSE_GUEST_EXTERNAL 6'h0A
`define CAUSE_HOST_GUEST_EXT 6'h0C

`define ALIGN_32 32

`endif

// [sim/hyp_trap_deleg_monitor.sv]
// checker for the trap delegation block ports
`timescale 1ns/10ps
`default_nettype none
module hyp_trap_deleg_monitor
#(
    parameter int HOST_WIDTH_32 = 0,
    parameter int INSTRUCTION_ALIGNMENT = 32
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic csr_read,
    input wire logic csr_write,
    input wire logic [2:0] csr_select,
    input wire logic [63:0] csr_rdata_q,
    input wire logic csr_missing_q,
    input wire logic exc_valid,
    input wire logic [5:0] exc_cause,
    input wire logic exc_routed_to_host,
    input wire logic guest_mode_before,
    input wire logic exc_to_guest_q,
    input wire logic at_host_level,
    input wire logic below_host_level,
    input wire logic sup_global_enable,
    input wire logic [63:0] sup_pending_enabled,
    input wire logic [63:0] host_routed,
    input wire logic [63:0] guest_ext_pending_vec,
    input wire logic [63:0] guest_ext_enable_vec,
    input wire logic host_irq_q,
    input wire logic [5:0] host_irq_cause_q,
    input wire logic guest_irq_q,
    input wire logic [5:0] guest_irq_cause_q,
    input wire logic host_guest_external_pending_q
);
    // ****************
    // output relations
    // ****************
    localparam logic [63:0] EXC_W = 64'hCB1FE | ((INSTRUCTION_ALIGNMENT == 32) ? 64'h1 : 64'h0);
    wire logic host_ok;
    assign host_ok = (at_host_level && sup_global_enable) || below_host_level;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    a_exc_to_guest:
        assert property (exc_to_guest_q |-> $past(exc_valid && exc_routed_to_host
            && guest_mode_before && EXC_W[exc_cause])) else $error("bad exception pass-on");
    a_host_needs_enable:
        assert property (host_irq_q |-> $past(host_ok)) else $error("host trap while disabled");
    a_guest_cause_xlate:
        assert property (guest_irq_q |-> guest_irq_cause_q inside {6'h01, 6'h05, 6'h09})
            else $error("guest cause untranslated");
    a_host_cause_set:
        assert property (host_irq_q |-> host_irq_cause_q inside {6'h09, 6'h01, 6'h05,
            6'h0C, 6'h0A, 6'h02, 6'h06}) else $error("host cause unknown");
    a_sup_ext_first:
        assert property ($past(arst_n && host_ok && sup_pending_enabled[9] && host_routed[9])
            |-> host_irq_q && host_irq_cause_q == 6'h09) else $error("external not first");
    a_sup_sw_next:
        assert property ($past(arst_n && host_ok && sup_pending_enabled[1] && host_routed[1]
            && !(sup_pending_enabled[9] && host_routed[9])) |-> host_irq_cause_q == 6'h01)
            else $error("software not second");
    a_host_guest_external_pending_and:
        assert property ($past(arst_n) |-> host_guest_external_pending_q ==
            |($past(guest_ext_pending_vec) & $past(guest_ext_enable_vec)))
            else $error("host guest-external pending wrong");
    a_missing_cause:
        assert property (csr_missing_q |-> $past((csr_read || csr_write) && (csr_select > 3'h5
            || (csr_select == 3'h1 && HOST_WIDTH_32 == 0)))) else $error("missing flag spurious");
    a_missing_flag:
        assert property ($past(arst_n && csr_read && csr_select == 3'h7) |-> csr_missing_q)
            else $error("missing flag absent");
    a_irq_deleg_zeros:
        assert property ($past(arst_n && csr_read && csr_select == 3'h2)
            |-> (csr_rdata_q & ~64'h444) == 64'h0) else $error("delegation zero bit set");
    a_inject_zeros:
        assert property ($past(arst_n && csr_read && csr_select == 3'h3)
            |-> (csr_rdata_q & ~64'h444) == 64'h0) else $error("injection zero bit set");
    a_enable_zeros:
        assert property ($past(arst_n && csr_read && csr_select == 3'h5)
            |-> (csr_rdata_q & ~64'h1444) == 64'h0) else $error("enable zero bit set");
endmodule
bind hyp_trap_deleg hyp_trap_deleg_monitor #(.HOST_WIDTH_32(HOST_WIDTH_32),
    .INSTRUCTION_ALIGNMENT(INSTRUCTION_ALIGNMENT)) mon_u (.*);
`default_nettype wire

// [sim/plat_irq_source.sv]
// platform interrupt sources driving the asynchronous guest pins
`timescale 1ns/10ps
`default_nettype none
module plat_irq_source
#(
    parameter real SKEW = 1.3
)
(
    input wire logic ext_req,
    input wire logic tmr_req,
    output wire logic ext_pin,
    output wire logic tmr_pin
);
    // ***************
    // pin drivers
    // ***************
    // pins move off the hart clock phase, as real sources do
    assign #(SKEW) ext_pin = ext_req;
    assign #(SKEW) tmr_pin = tmr_req;
endmodule
`default_nettype wire

// [sim/hyp_trap_deleg_bench.sv]
// self-checking bench for the trap delegation block
`timescale 1ns/10ps
`default_nettype none
module hyp_trap_deleg_bench;
    logic clock = 1'b0, arst_n = 1'b0, csr_read = 1'b0, csr_write = 1'b0;
    logic [2:0] csr_select = 3'h0;
    logic [63:0] csr_wdata = 64'h0, sup_pending_enabled = 64'h0, host_routed = ~64'h0;
    logic [63:0] guest_ext_pending_vec = 64'h0, guest_ext_enable_vec = 64'h0;
    logic exc_valid = 1'b0, exc_routed_to_host = 1'b0, guest_mode_before = 1'b0;
    logic [5:0] exc_cause = 6'h0, guest_external_source_select = 6'h0;
    logic at_host_level = 1'b0, below_host_level = 1'b0, sup_global_enable = 1'b0;
    logic ext_req = 1'b0, tmr_req = 1'b0, platform_guest_external, platform_guest_timer;
    logic [63:0] csr_rdata_q;
    logic csr_missing_q, exc_to_guest_q, host_irq_q, guest_irq_q, host_guest_external_pending_q;
    logic [5:0] host_irq_cause_q, guest_irq_cause_q;
    logic [63:0] rdata32;
    logic miss32;
    int n_errors = 0, cmp_count = 0, i;
    logic [2:0] sel_t [4] = '{3'h0, 3'h2, 3'h3, 3'h5};
    logic [63:0] mask_t [4] = '{64'hCB1FF, 64'h444, 64'h444, 64'h1444};
    logic [63:0] sup_t [7] = '{64'h222, 64'h22, 64'h20, 64'h0, 64'h0, 64'h0, 64'h0};
    logic [63:0] inj_t [7] = '{64'h444, 64'h444, 64'h444, 64'h444, 64'h444, 64'h44, 64'h40};
    logic [5:0] cause_t [7] = '{6'h09, 6'h01, 6'h05, 6'h0C, 6'h0A, 6'h02, 6'h06};
    hyp_trap_deleg #(.HOST_WIDTH_32(0), .INSTRUCTION_ALIGNMENT(32)) dut_u (.*);
    // 32-bit host width with 16-bit alignment: upper alias exists, bit 0 stays zero
    hyp_trap_deleg #(.HOST_WIDTH_32(1), .INSTRUCTION_ALIGNMENT(16)) dut32_u (.*,
        .csr_rdata_q(rdata32), .csr_missing_q(miss32), .exc_to_guest_q(), .host_irq_q(),
        .host_irq_cause_q(), .guest_irq_q(), .guest_irq_cause_q(),
        .host_guest_external_pending_q());
    plat_irq_source plat_u (.ext_req(ext_req), .tmr_req(tmr_req),
        .ext_pin(platform_guest_external), .tmr_pin(platform_guest_timer));
    // ***************
    // access tasks
    // ***************
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [2:0] sel, input logic [63:0] d);
        csr_select = sel;
        csr_wdata = d;
        csr_write = 1'b1;
        cyc(1);
        csr_write = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [2:0] sel, input logic [63:0] exp, input logic miss);
        csr_select = sel;
        csr_read = 1'b1;
        cyc(1);
        csr_read = 1'b0;
        check(64'(csr_missing_q), 64'(miss));
        cyc(1);
        if (!miss)
            check(csr_rdata_q, exp);
    endtask
    task automatic rd32(input logic [2:0] sel, input logic [63:0] exp);
        csr_select = sel;
        csr_read = 1'b1;
        cyc(1);
        csr_read = 1'b0;
        check(64'(miss32), 64'h0);
        cyc(1);
        check(rdata32, exp);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
        forever #2 clock = ~clock;
    initial
    begin
        #20000;
        n_errors = n_errors + 1;
        tally_and_finish;
    end
    initial
    begin
        repeat (4) @(posedge clock);
        #1;
        arst_n = 1'b1;
        for (i = 0; i < 8; i++)
            rd(i[2:0], 64'h0, i == 1 || i > 5);
        $display("reset values done");
        for (i = 0; i < 4; i++)
        begin
            wr(sel_t[i], ~64'h0);
            rd(sel_t[i], mask_t[i], 1'b0);
        end
        rd32(3'h0, 64'hCB1FE);
        wr(3'h1, ~64'h0);
        rd32(3'h1, 64'h0);
        wr(3'h1, 64'h0);
        rd32(3'h0, 64'hCB1FE);
        rd(3'h4, 64'h444, 1'b0);
        wr(3'h4, 64'h0);
        rd(3'h4, 64'h440, 1'b0);
        rd(3'h3, 64'h440, 1'b0);
        wr(3'h4, ~64'h0);
        rd(3'h3, 64'h444, 1'b0);
        $display("register masks done");
        for (i = 0; i < 3; i++)
        begin
            wr(3'h3, 64'h4 << (4 * i));
            cyc(1);
            check(64'(guest_irq_q), 64'h1);
            check(64'(guest_irq_cause_q), 64'(1 + 4 * i));
        end
        wr(3'h3, 64'h0);
        rd(3'h4, 64'h0, 1'b0);
        $display("guest translation done");
        guest_ext_pending_vec = 64'h7;
        guest_ext_enable_vec = 64'h4;
        rd(3'h4, 64'h1000, 1'b0);
        check(64'(host_guest_external_pending_q), 64'h1);
        guest_ext_enable_vec = 64'h8;
        guest_external_source_select = 6'h2;
        rd(3'h4, 64'h400, 1'b0);
        check(64'(host_guest_external_pending_q), 64'h0);
        guest_ext_pending_vec = 64'h0;
        tmr_req = 1'b1;
        cyc(4);
        rd(3'h4, 64'h40, 1'b0);
        tmr_req = 1'b0;
        ext_req = 1'b1;
        cyc(4);
        rd(3'h4, 64'h400, 1'b0);
        ext_req = 1'b0;
        cyc(4);
        $display("pending sources done");
        exc_routed_to_host = 1'b1;
        guest_mode_before = 1'b1;
        exc_valid = 1'b1;
        for (i = 0; i < 26; i++)
        begin
            exc_cause = i[5:0];
            cyc(1);
            check(64'(exc_to_guest_q), (64'hCB1FF >> i) & 64'h1);
        end
        exc_cause = 6'h2;
        guest_mode_before = 1'b0;
        cyc(1);
        check(64'(exc_to_guest_q), 64'h0);
        guest_mode_before = 1'b1;
        exc_routed_to_host = 1'b0;
        cyc(1);
        check(64'(exc_to_guest_q), 64'h0);
        exc_valid = 1'b0;
        $display("exception routing done");
        wr(3'h2, 64'h0);
        at_host_level = 1'b1;
        sup_global_enable = 1'b1;
        for (i = 0; i < 7; i++)
        begin
            sup_pending_enabled = sup_t[i];
            guest_ext_pending_vec = (i < 4) ? 64'h2 : 64'h0;
            guest_ext_enable_vec = guest_ext_pending_vec;
            wr(3'h3, inj_t[i]);
            cyc(1);
            check(64'(host_irq_q), 64'h1);
            check(64'(host_irq_cause_q), 64'(cause_t[i]));
        end
        sup_global_enable = 1'b0;
        cyc(2);
        check(64'(host_irq_q), 64'h0);
        at_host_level = 1'b0;
        below_host_level = 1'b1;
        cyc(2);
        check(64'(host_irq_q), 64'h1);
        wr(3'h2, 64'h40);
        cyc(1);
        check(64'(host_irq_q), 64'h0);
        check(64'(guest_irq_cause_q), 64'h5);
        host_routed = ~64'h40;
        cyc(2);
        check(64'(guest_irq_q), 64'h0);
        $display("host priority done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
